// file: ocpwm_channel.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Control bit 3 picks the second timer; clear means the first timer.
// - Modes 001, 010, 011 force low, force high or toggle on a match.
// - A wrap to zero without a match leaves the pin as it was.
// - Mode 100 gives one pulse, mode 101 a continuous pulse train.
// - Main value match starts the pulse, secondary value match ends it.
// - After one pulse, another comes only when mode 100 is written again.
// - Modes 110, 111 are PWM; main is a read-only latch of the buffered duty.
// - Mode 111 with fault input low floats the pin and, outside Sleep, sets the fault flag.
// - Once the flag is set, float lasts until fault input is high and a PWM mode (110 or 111) is written.
// - PWM period is period value plus one timer increments.
// - Period rollover sets the pin unless the new duty is zero, reloads the duty latch and flags the timer.
// - Duty zero keeps the pin low; duty above period keeps it high.
// - In Sleep the pin holds its level; operation resumes on wake-up.
// - In Idle it runs only with own and timer halt bits clear and timer on.
// - Outside PWM every compare event sets the compare flag; software clears it.
// - In PWM the compare flag never sets; the timer flag marks each period.
module ocpwm_channel
  import ocpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ocpwm_timer_t first_timer,
  input wire ocpwm_timer_t second_timer,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic fault_input_pin,
  output logic compare_output_pin_o,
  output logic compare_output_pin_oe,
  output logic compare_irq_flag,
  output logic first_timer_irq_flag,
  output logic second_timer_irq_flag
);

  // ------------------------------------------------------------
  // Registers and nets
  // ------------------------------------------------------------
  logic [2:0] mode_q;
  logic tsel_q;
  logic sidl_q;
  logic fault_flag_q;
  logic [15:0] main_q;
  logic [15:0] secondary_q;
  logic pulse_done_q;
  logic pin_q;
  logic pin_oe_q;
  logic cmp_flag_q;
  logic t1_flag_q;
  logic t2_flag_q;
  logic [2:0] flt_sync_q;
  logic flt_level_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  ocpwm_timer_t tmr;
  logic access;
  logic xfer_done;
  logic wr_done;
  logic wr_ctrl;
  logic wr_main;
  logic wr_sec;
  logic wr_stat;
  logic mapped;
  logic is_pwm;
  logic is_single;
  logic is_dual;
  logic running;
  logic tick;
  logic main_hit;
  logic sec_hit;
  logic period_hit;
  logic cmp_event;
  logic [2:0] new_mode;
  logic [31:0] rd_word;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign access = psel && penable;
  assign xfer_done = access && pready_q;
  assign wr_done = xfer_done && pwrite && !pslverr_q;
  assign wr_ctrl = wr_done && (paddr == OCPWM_CONTROL_OFS);
  assign wr_main = wr_done && (paddr == OCPWM_MAIN_OFS);
  assign wr_sec = wr_done && (paddr == OCPWM_SECONDARY_OFS);
  assign wr_stat = wr_done && (paddr == OCPWM_STATUS_OFS);
  assign mapped = (paddr == OCPWM_CONTROL_OFS) || (paddr == OCPWM_MAIN_OFS) ||
                  (paddr == OCPWM_SECONDARY_OFS) || (paddr == OCPWM_STATUS_OFS);
  assign new_mode = pwdata[OCPWM_MODE_LSB +: 3];

  // ------------------------------------------------------------
  // Time base and compare events
  // ------------------------------------------------------------
  assign tmr = tsel_q ? second_timer : first_timer;
  assign is_pwm = (mode_q == OCPWM_PWM) || (mode_q == OCPWM_PWM_FAULT);
  assign is_single = (mode_q == OCPWM_FORCE_LOW) || (mode_q == OCPWM_FORCE_HIGH) ||
                     (mode_q == OCPWM_TOGGLE);
  assign is_dual = (mode_q == OCPWM_ONE_PULSE) || (mode_q == OCPWM_CONT_PULSE);
  // Sleep stops the time base, so the pin keeps its last level
  assign running = !sleep_mode && tmr.run &&
                   !(idle_mode && (sidl_q || tmr.halt_idle));
  // A tick while count sits on a value means the count reached it
  assign tick = running && tmr.tick && (mode_q != OCPWM_OFF);
  assign main_hit = tick && (tmr.count == main_q);
  assign sec_hit = tick && (tmr.count == secondary_q);
  assign period_hit = tick && (tmr.count == tmr.period);
  assign cmp_event = (is_single && main_hit) ||
                     (is_dual && !pulse_done_q && (main_hit || sec_hit));

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= OCPWM_MODE_RST;
      tsel_q <= 1'b0;
      sidl_q <= 1'b0;
    end else if (wr_ctrl) begin
      mode_q <= new_mode;
      tsel_q <= pwdata[OCPWM_TSEL_BIT];
      sidl_q <= pwdata[OCPWM_SIDL_BIT];
    end
  end

  // ------------------------------------------------------------
  // Compare values
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_q <= OCPWM_VALUE_RST;
    end else if (wr_sec) begin
      secondary_q <= pwdata[15:0];
    end
  end

  // Main value is read-only while PWM owns it as the duty latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_q <= OCPWM_VALUE_RST;
    end else if (is_pwm && period_hit) begin
      main_q <= secondary_q;
    end else if (wr_main && !is_pwm) begin
      main_q <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Fault input: three stages, level moves when stages two and three agree
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_sync_q <= 3'h7;
    end else begin
      flt_sync_q <= {flt_sync_q[1:0], fault_input_pin};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_level_q <= 1'b1;
    end else if (flt_sync_q[1] == flt_sync_q[2]) begin
      flt_level_q <= flt_sync_q[2];
    end
  end

  // Set wins over the re-enable write while the fault is still low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag_q <= 1'b0;
    end else if (mode_q == OCPWM_PWM_FAULT && !flt_level_q && !sleep_mode) begin
      fault_flag_q <= 1'b1;
    end else if (wr_ctrl && flt_level_q && new_mode[2:1] == 2'b11) begin
      fault_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_q <= 1'b1;
    end else begin
      pin_oe_q <= !(fault_flag_q || (mode_q == OCPWM_PWM_FAULT && !flt_level_q));
    end
  end

  // ------------------------------------------------------------
  // One-pulse bookkeeping
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_done_q <= 1'b0;
    end else if (wr_ctrl) begin
      pulse_done_q <= 1'b0;
    end else if (mode_q == OCPWM_ONE_PULSE && sec_hit && !pulse_done_q) begin
      pulse_done_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Output pin
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else if (mode_q == OCPWM_OFF) begin
      pin_q <= 1'b0;
      // A wrap with no match falls through, so the pin keeps its level
    end else if (is_single && main_hit) begin
      case (mode_q)
        OCPWM_FORCE_LOW: begin
          pin_q <= 1'b0;
        end
        OCPWM_FORCE_HIGH: begin
          pin_q <= 1'b1;
        end
        OCPWM_TOGGLE: begin
          pin_q <= !pin_q;
        end
        default: begin
          pin_q <= pin_q;
        end
      endcase
    end else if (is_dual && !pulse_done_q && sec_hit) begin
      pin_q <= 1'b0;
    end else if (is_dual && !pulse_done_q && main_hit) begin
      pin_q <= 1'b1;
    end else if (is_pwm && period_hit) begin
      pin_q <= (secondary_q != 16'h0000);
    end else if (is_pwm && main_hit) begin
      // Duty above period never matches, so the pin stays high
      pin_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Event flags (write one to clear, set wins)
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_flag_q <= 1'b0;
    end else if (cmp_event && !is_pwm) begin
      cmp_flag_q <= 1'b1;
    end else if (wr_stat && pwdata[OCPWM_ST_CMP_BIT]) begin
      cmp_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_flag_q <= 1'b0;
    end else if (is_pwm && period_hit && !tsel_q) begin
      t1_flag_q <= 1'b1;
    end else if (wr_stat && pwdata[OCPWM_ST_T1_BIT]) begin
      t1_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_flag_q <= 1'b0;
    end else if (is_pwm && period_hit && tsel_q) begin
      t2_flag_q <= 1'b1;
    end else if (wr_stat && pwdata[OCPWM_ST_T2_BIT]) begin
      t2_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read mux and bus answer
  // ------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      OCPWM_SECONDARY_OFS: begin
        rd_word[15:0] = secondary_q;
      end
      OCPWM_MAIN_OFS: begin
        rd_word[15:0] = main_q;
      end
      OCPWM_CONTROL_OFS: begin
        rd_word[OCPWM_MODE_LSB +: 3] = mode_q;
        rd_word[OCPWM_TSEL_BIT] = tsel_q;
        rd_word[OCPWM_FLT_BIT] = fault_flag_q;
        rd_word[OCPWM_SIDL_BIT] = sidl_q;
      end
      OCPWM_STATUS_OFS: begin
        rd_word[OCPWM_ST_CMP_BIT] = cmp_flag_q;
        rd_word[OCPWM_ST_T1_BIT] = t1_flag_q;
        rd_word[OCPWM_ST_T2_BIT] = t2_flag_q;
        rd_word[OCPWM_ST_PIN_BIT] = pin_q;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // One wait state so every bus output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign compare_output_pin_o = pin_q;
  assign compare_output_pin_oe = pin_oe_q;
  assign compare_irq_flag = cmp_flag_q;
  assign first_timer_irq_flag = t1_flag_q;
  assign second_timer_irq_flag = t2_flag_q;

endmodule : ocpwm_channel

`default_nettype wire

// file: ocpwm_channel_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ocpwm_channel_monitor
  import ocpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire ocpwm_timer_t first_timer,
  input wire ocpwm_timer_t second_timer,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic fault_input_pin,
  input wire logic compare_output_pin_o,
  input wire logic compare_output_pin_oe,
  input wire logic compare_irq_flag,
  input wire logic first_timer_irq_flag,
  input wire logic second_timer_irq_flag
);
  // ----------
  // Shadow state
  // ----------
  logic [2:0] mode_q;
  logic tsel_q;
  logic sidl_q;
  logic [15:0] main_q;
  logic [15:0] sec_q;
  logic wr;
  logic ctl;
  logic pwm;
  logic ev;
  logic hit;
  logic roll;
  logic po;
  logic oe;
  ocpwm_timer_t tm;
  assign po = compare_output_pin_o;
  assign oe = compare_output_pin_oe;
  assign wr = psel && penable && pready && pwrite;
  assign ctl = wr && paddr == OCPWM_CONTROL_OFS;
  assign pwm = mode_q[2:1] == 2'h3;
  assign tm = tsel_q ? second_timer : first_timer;
  assign ev = tm.tick && tm.run && !sleep_mode && !(idle_mode && (sidl_q || tm.halt_idle));
  assign hit = ev && tm.count == main_q;
  // Duty equal to period is avoided by the bench: match and rollover would collide
  assign roll = ev && tm.count == tm.period && pwm && oe && !wr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 3'h0;
      tsel_q <= 1'b0;
      sidl_q <= 1'b0;
    end else if (ctl) begin
      mode_q <= pwdata[2:0];
      tsel_q <= pwdata[3];
      sidl_q <= pwdata[13];
    end
  end
  // Main writes are dropped in PWM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_q <= 16'h0000;
      sec_q <= 16'h0000;
    end else if (wr) begin
      if (paddr == OCPWM_MAIN_OFS && !pwm) begin
        main_q <= pwdata[15:0];
      end
      if (paddr == OCPWM_SECONDARY_OFS) begin
        sec_q <= pwdata[15:0];
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_fault;
    (mode_q == 3'h7 && !fault_input_pin) [*8];
  endsequence
  sequence s_pwm_quiet;
    pwm && $past(pwm) && !compare_irq_flag;
  endsequence
  a_force_level: assert property (
    hit && mode_q inside {3'h1, 3'h2} |=> po == $past(mode_q[1]) && compare_irq_flag)
    else $error("force match wrong");
  a_toggle_pin: assert property (hit && mode_q == 3'h3 |=> po != $past(po))
    else $error("toggle missing");
  a_miss_hold: assert property (
    ev && !hit && mode_q inside {3'h1, 3'h2, 3'h3} && !wr |=> $stable(po))
    else $error("pin moved without match");
  a_off_low: assert property (mode_q == 3'h0 && !wr |=> !po)
    else $error("pin high while off");
  a_sleep_hold: assert property (sleep_mode && !wr |=> $stable(po) && $stable(oe))
    else $error("pin moved in sleep");
  a_pwm_noflag: assert property (s_pwm_quiet |=> !compare_irq_flag)
    else $error("compare flag in pwm");
  a_pwm_roll: assert property (
    roll |=> po == (sec_q != 16'h0000) &&
      (tsel_q ? second_timer_irq_flag : first_timer_irq_flag))
    else $error("rollover wrong");
  a_fault_float: assert property (s_fault |-> !oe)
    else $error("pin driven in fault");
  // Clearing write lands on the flag first; the enable follows one edge later
  a_fault_hold: assert property (!oe && !ctl && !$past(ctl) |=> !oe)
    else $error("float left early");
endmodule : ocpwm_channel_monitor
bind ocpwm_channel ocpwm_channel_monitor i_ocpwm_channel_monitor (.*);
`default_nettype wire

// file: ocpwm_load.sv
`timescale 1ns/100ps
`default_nettype none
module ocpwm_load (
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic fault_req,
  output logic pad,
  output logic fault_n
);
  // ----------
  // Power stage
  // ----------
  // Gate pull-down: a floated pin reads low
  assign pad = pin_oe ? pin_o : 1'b0;
  // Open-drain fault line with pull-up
  assign fault_n = !fault_req;
endmodule : ocpwm_load
`default_nettype wire

// file: ocpwm_pkg.sv
package ocpwm_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OCPWM_SECONDARY_OFS = 8'h00;
  localparam logic [7:0] OCPWM_MAIN_OFS = 8'h04;
  localparam logic [7:0] OCPWM_CONTROL_OFS = 8'h08;
  localparam logic [7:0] OCPWM_STATUS_OFS = 8'h0C;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int OCPWM_MODE_LSB = 0;
  localparam int OCPWM_TSEL_BIT = 3;
  localparam int OCPWM_FLT_BIT = 4;
  localparam int OCPWM_SIDL_BIT = 13;
  localparam int OCPWM_ST_CMP_BIT = 0;
  localparam int OCPWM_ST_T1_BIT = 1;
  localparam int OCPWM_ST_T2_BIT = 2;
  localparam int OCPWM_ST_PIN_BIT = 8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] OCPWM_VALUE_RST = 16'h0000;
  localparam logic [2:0] OCPWM_MODE_RST = 3'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OCPWM_OFF = 3'b000,
    OCPWM_FORCE_LOW = 3'b001,
    OCPWM_FORCE_HIGH = 3'b010,
    OCPWM_TOGGLE = 3'b011,
    OCPWM_ONE_PULSE = 3'b100,
    OCPWM_CONT_PULSE = 3'b101,
    OCPWM_PWM = 3'b110,
    OCPWM_PWM_FAULT = 3'b111
  } ocpwm_mode_t;

  // One shared timer as seen by the channel
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic tick;
    logic run;
    logic halt_idle;
  } ocpwm_timer_t;

endpackage : ocpwm_pkg

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ocpwm_pkg::*;
  // ----------
  // Stimulus
  // ----------
  typedef struct {logic [2:0] m; logic s; logic [15:0] v; logic [31:0] st;} ocpwm_row_t;
  ocpwm_row_t rows [6] = '{'{3'h2, 1'b0, 16'h0005, 32'h101}, '{3'h1, 1'b0, 16'h0014, 32'h100},
    '{3'h0, 1'b0, 16'h0003, 32'h000}, '{3'h3, 1'b0, 16'h0003, 32'h101},
    '{3'h1, 1'b1, 16'h0004, 32'h001}, '{3'h2, 1'b1, 16'h0007, 32'h101}};
  logic [15:0] duty [2] = '{16'h0000, 16'h0014};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  logic fault_req = 1'b0;
  ocpwm_timer_t t1 = '{16'h0000, 16'h000F, 1'b1, 1'b0, 1'b0};
  ocpwm_timer_t t2 = '{16'h0000, 16'h000F, 1'b1, 1'b0, 1'b0};
  logic fault_n;
  logic pin_o;
  logic pin_oe;
  logic pad;
  logic cmp_irq;
  logic t1_irq;
  logic t2_irq;
  logic [31:0] rd;
  logic err;
  logic p;
  int hc;
  int num_errors = 0;
  int total_checks = 0;
  ocpwm_channel i_ocpwm_channel (.*, .first_timer(t1), .second_timer(t2),
    .fault_input_pin(fault_n), .compare_output_pin_o(pin_o), .compare_output_pin_oe(pin_oe),
    .compare_irq_flag(cmp_irq), .first_timer_irq_flag(t1_irq), .second_timer_irq_flag(t2_irq));
  ocpwm_load i_ocpwm_load (.pin_o(pin_o), .pin_oe(pin_oe), .fault_req(fault_req), .pad(pad),
    .fault_n(fault_n));
  always #2 pclk = ~pclk;
  // Stopped timers clear, so every run starts at count zero
  always @(posedge pclk) begin
    t1.count <= t1.run && t1.count != t1.period ? t1.count + 16'h1 : 16'h0;
    t2.count <= t2.run && t2.count != t2.period ? t2.count + 16'h1 : 16'h0;
  end
  task automatic close_out;
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      num_errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Pre-edge values are what the slave showed at this edge
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic meas(input int n);
    hc = 0;
    repeat (n) begin
      @(negedge pclk);
      hc += (pad === 1'b1);
    end
  endtask : meas
  task automatic go(input logic s, input int n);
    @(posedge pclk);
    t1.run <= !s;
    t2.run <= s;
    meas(n);
    @(posedge pclk);
    t1.run <= 1'b0;
    t2.run <= 1'b0;
  endtask : go
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    chk({29'h0, pin_oe, pin_o, cmp_irq}, 32'h4);
    foreach (rows[i]) begin
      apb(1'b1, OCPWM_STATUS_OFS, 32'h7);
      apb(1'b1, OCPWM_MAIN_OFS, {16'h0, rows[i].v});
      apb(1'b1, OCPWM_CONTROL_OFS, {28'h0, rows[i].s, rows[i].m});
      apb(1'b0, OCPWM_CONTROL_OFS, 32'h0);
      chk(rd, {28'h0, rows[i].s, rows[i].m});
      // Long enough for one wrap, short of a second match
      go(rows[i].s, 18);
      apb(1'b0, OCPWM_STATUS_OFS, 32'h0);
      chk(rd & 32'h101, rows[i].st);
      chk({31'h0, cmp_irq}, {31'h0, rows[i].st[0]});
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, OCPWM_CONTROL_OFS, 32'h0);
    apb(1'b1, OCPWM_MAIN_OFS, 32'h3);
    apb(1'b1, OCPWM_SECONDARY_OFS, 32'h6);
    apb(1'b1, OCPWM_CONTROL_OFS, 32'h4);
    go(1'b0, 40);
    chk(hc, 3);
    go(1'b0, 40);
    chk(hc, 0);
    apb(1'b1, OCPWM_CONTROL_OFS, 32'h4);
    go(1'b0, 40);
    chk(hc, 3);
    apb(1'b1, OCPWM_CONTROL_OFS, 32'h5);
    go(1'b0, 32);
    chk(hc, 6);
    apb(1'b1, OCPWM_SECONDARY_OFS, 32'h5);
    apb(1'b1, OCPWM_CONTROL_OFS, 32'h6);
    @(posedge pclk);
    t1.run <= 1'b1;
    meas(16);
    meas(32);
    // Match acts on the tick leaving the duty count: six high cycles a period
    chk(hc, 12);
    apb(1'b1, OCPWM_MAIN_OFS, 32'hF);
    apb(1'b0, OCPWM_MAIN_OFS, 32'h0);
    chk(rd, 32'h5);
    foreach (duty[i]) begin
      apb(1'b1, OCPWM_SECONDARY_OFS, {16'h0, duty[i]});
      meas(16);
      apb(1'b1, OCPWM_STATUS_OFS, 32'h7);
      meas(32);
      chk(hc, 32 * i);
    end
    apb(1'b0, OCPWM_STATUS_OFS, 32'h0);
    chk(rd, 32'h102);
    apb(1'b1, OCPWM_SECONDARY_OFS, 32'h5);
    meas(16);
    @(posedge pclk);
    sleep_mode <= 1'b1;
    @(negedge pclk);
    p = pad;
    meas(20);
    chk(hc, p ? 20 : 0);
    @(posedge pclk);
    sleep_mode <= 1'b0;
    meas(16);
    meas(32);
    chk(hc, 12);
    @(posedge pclk);
    idle_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OCPWM_CONTROL_OFS, i ? 32'h6 : 32'h2006);
      apb(1'b1, OCPWM_STATUS_OFS, 32'h7);
      meas(40);
      apb(1'b0, OCPWM_STATUS_OFS, 32'h0);
      chk(rd & 32'h7, i ? 32'h2 : 32'h0);
      chk({29'h0, t2_irq, t1_irq, cmp_irq}, i ? 32'h2 : 32'h0);
    end
    @(posedge pclk);
    idle_mode <= 1'b0;
    // PWM on the second timer: only its own flag may rise
    apb(1'b1, OCPWM_CONTROL_OFS, 32'hE);
    apb(1'b1, OCPWM_STATUS_OFS, 32'h7);
    go(1'b1, 40);
    chk({29'h0, t2_irq, t1_irq, cmp_irq}, 32'h4);
    apb(1'b1, OCPWM_CONTROL_OFS, 32'h7);
    @(posedge pclk);
    fault_req <= 1'b1;
    meas(10);
    apb(1'b0, OCPWM_CONTROL_OFS, 32'h0);
    chk({rd[31:1], pin_oe}, 32'h16);
    @(posedge pclk);
    fault_req <= 1'b0;
    meas(10);
    chk({31'h0, pin_oe}, 32'h0);
    apb(1'b1, OCPWM_CONTROL_OFS, 32'h7);
    meas(10);
    apb(1'b0, OCPWM_CONTROL_OFS, 32'h0);
    chk({rd[31:1], pin_oe}, 32'h7);
    close_out();
  end
endmodule : tb
`default_nettype wire
